// ==== inc/fpx_cfg.svh ====
// Offsets, field positions, widths and exponent limits of the
// floating-point underflow/inexact result unit.
// Assumes inclusion by bare name from interface, design and bench files.
`ifndef FPX_CFG_SVH
`define FPX_CFG_SVH

// ------------------------------------------------------------
// Datapath widths
// ------------------------------------------------------------
`define SIG_W      64
`define EXP_W      14
`define BE_W       12
`define MANT_W     53
`define SH_W       7
`define RES_W      64
`define HALF_W     32
`define SP_MANT    24
`define DP_MANT    53
`define SP_EXP_W   8
`define DP_EXP_W   11

// ------------------------------------------------------------
// Exponent limits, biases and trap scaling
// ------------------------------------------------------------
`define SP_EMIN    (-14'sd126)
`define SP_EMAX    14'sd127
`define SP_BIAS    14'sd127
`define SP_SCALE   14'sd192
`define DP_EMIN    (-14'sd1022)
`define DP_EMAX    14'sd1023
`define DP_BIAS    14'sd1023
`define DP_SCALE   14'sd1536
`define EXP_ONE    14'sd1
`define SHIFT_LIM  14'sd127
`define SHIFT_MAX  7'h7f
`define SP_EXP_INF 12'h0ff
`define DP_EXP_INF 12'h7ff
`define SP_EXP_MAX 12'h0fe
`define DP_EXP_MAX 12'h7fe
`define EXP_DN     12'h000
`define EXP_MINN   12'h001

// ------------------------------------------------------------
// Register port
// ------------------------------------------------------------
`define ADDR_W     4
`define DATA_W     32
`define CTRL_OFS   4'h0
`define STAT_OFS   4'h1
`define IRQM_OFS   4'h2
`define CTRL_W     5
`define CTRL_RST   5'h1c
`define CTL_RM     0
`define CTL_PM     2
`define CTL_UM     3
`define CTL_OM     4
`define FL_W       3
`define ST_W       4
`define FL_PE      0
`define FL_UE      1
`define FL_OE      2
`define ST_TRAP    3

`endif

// ==== inc/fpx_pkg.sv ====
// Types shared by the result unit and its rounder.
// Assumes fpx_cfg.svh holds all numeric constants.
package fpx_pkg;

   // ------------------------------------------------------------
   // Rounding directions and operation classes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      RM_NEAR = 2'b00,
      RM_DOWN = 2'b01,
      RM_UP   = 2'b10,
      RM_ZERO = 2'b11
   } rm_t;

   typedef enum logic [2:0] {
      OP_ARITH  = 3'b000,
      OP_NARROW = 3'b001,
      OP_SQRT   = 3'b010,
      OP_CVT_FF = 3'b011,
      OP_CVT_IF = 3'b100,
      OP_CVT_FI = 3'b101,
      OP_CVT_FIT = 3'b110
   } op_class_t;

endpackage : fpx_pkg

// ==== inc/fpx_rnd_if.sv ====
// Request and answer of one rounding slice.
// Assumes a purely combinational rounder on the rnd side.
`include "fpx_cfg.svh"
interface fpx_rnd_if;
   import fpx_pkg::*;
   logic [`SIG_W-1:0]  sig;
   logic [`SH_W-1:0]   shift;
   logic               dp;
   rm_t                rm;
   logic               sign;
   logic [`MANT_W-1:0] mant;
   logic               carry;
   logic               inexact;
   modport core (output sig, shift, dp, rm, sign,
                 input  mant, carry, inexact);
   modport rnd  (input  sig, shift, dp, rm, sign,
                 output mant, carry, inexact);
endinterface : fpx_rnd_if

// ==== rtl/fpx_round.sv ====
// Rounder: right shift with sticky, then round to 24 or 53 bits.
// Assumes the significand arrives with its leading one at the top.
`include "fpx_cfg.svh"
module fpx_round (
   // Rounding slice
   fpx_rnd_if.rnd r
);
   import fpx_pkg::*;

   logic [2*`SIG_W-1:0] ext;
   logic [`SIG_W-1:0]   sh;
   logic [`MANT_W-1:0]  tr;
   logic [`MANT_W:0]    sum;
   logic                lost;
   logic                g;
   logic                st;
   logic                inc;

   always_comb begin
      ext  = {r.sig, {`SIG_W{1'b0}}} >> r.shift;
      sh   = ext[2*`SIG_W-1 -: `SIG_W];
      lost = |ext[`SIG_W-1:0];
      if (r.dp) begin
         tr = sh[`SIG_W-1 -: `DP_MANT];
         g  = sh[`SIG_W-1-`DP_MANT];
         st = |(sh << (`DP_MANT + 1)) | lost;
      end else begin
         tr = `MANT_W'(sh[`SIG_W-1 -: `SP_MANT]);
         g  = sh[`SIG_W-1-`SP_MANT];
         st = |(sh << (`SP_MANT + 1)) | lost;
      end
      case (r.rm)
         RM_NEAR: inc = g & (st | tr[0]);
         RM_UP:   inc = ~r.sign & (g | st);
         RM_DOWN: inc = r.sign & (g | st);
         default: inc = 1'b0;
      endcase
      sum       = {1'b0, tr} + {{`MANT_W{1'b0}}, inc};
      r.inexact = g | st;
      r.carry   = r.dp ? sum[`DP_MANT] : sum[`SP_MANT];
      // Carry out renormalises to a lone leading one
      if (r.carry) begin
         r.mant = r.dp ? `MANT_W'(1) << (`DP_MANT - 1)
                       : `MANT_W'(1) << (`SP_MANT - 1);
      end else begin
         r.mant = sum[`MANT_W-1:0];
      end
   end

endmodule : fpx_round

// ==== rtl/fpx_unit.sv ====
// Underflow, overflow and inexact result stage for packed and
// scalar floating-point operations, with sticky flags and interrupt.
// Assumes an upstream core hands over per lane the exact result as
// sign, unbounded exponent and normalised significand with sticky LSB.
//
// Notes on behaviour
// RULE1: Single: tiny after rounding with unbounded exponent signals underflow.
// RULE2: Double: tiny after rounding with unbounded exponent signals underflow.
// RULE3: Underflow only for arithmetic and narrowing, never sqrt or integer.
// RULE4: Masked underflow: zero/denormal/normal; flags only if inexact.
// RULE5: Unmasked single underflow: scale up by 2^192, flag, inexact. Here inexact is flagged only when the rounding is inexact.
// RULE6: Unmasked double underflow: scale up by 2^1536 and flag.
// RULE7: Inexact raised when exact result is not representable.
// RULE8: Inexact covers arithmetic, sqrt and all conversions incl truncating.
// RULE9: Masked inexact: flag, bounded-exponent result if no unmasked U/O.
// RULE10: Inexact may be reported with masked underflow or overflow.
// RULE11: Unmasked inexact acts only without unmasked underflow or overflow.
// RULE12: Unmasked inexact with masked overflow: overflow flag, masked result.
// RULE13: Unmasked inexact with masked underflow: underflow flag, masked result.
// RULE14: Unmasked inexact alone: bounded-exponent result and inexact flag.
// RULE15: Masked overflow: infinity or largest finite per rounding, O and P.
// RULE16: Packed lanes evaluated apart; flags ORed into sticky status.
//
// Chosen here: the plain strobed port and the placing of the registers.
`include "fpx_cfg.svh"
module fpx_unit #(
   parameter int LANES = 4
) (
   // Clock and reset
   input  wire logic                           core_clk_in,
   input  wire logic                           nrst_in,
   // Operation from the arithmetic core
   input  wire logic                           op_valid_in,
   input  wire fpx_pkg::op_class_t             op_class_in,
   input  wire logic                           dp_in,
   input  wire logic [LANES-1:0]               lane_en_in,
   input  wire logic [LANES-1:0]               sign_in,
   input  wire logic [LANES-1:0]               zero_in,
   input  wire logic [LANES-1:0][`EXP_W-1:0]   exp_in,
   input  wire logic [LANES-1:0][`SIG_W-1:0]   sig_in,
   // Delivered result
   output logic                                res_valid_out,
   output logic [LANES-1:0][`RES_W-1:0]        res_out,
   output logic [`FL_W-1:0]                    flags_out,
   output logic [`FL_W-1:0]                    cause_out,
   output logic                                trap_out,
   // Register port
   input  wire logic [`ADDR_W-1:0]             reg_addr_in,
   input  wire logic [`DATA_W-1:0]             reg_wdata_in,
   input  wire logic                           reg_wr_in,
   input  wire logic                           reg_rd_in,
   output logic [`DATA_W-1:0]                  reg_rdata_out,
   // Interrupt
   output logic                                irq_out
);
   import fpx_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [`RES_W-1:0] enc(input logic dp,
                                             input logic s,
                                             input logic [`BE_W-1:0] be,
                                             input logic [`MANT_W-1:0] m);
      if (dp) begin
         enc = {s, be[`DP_EXP_W-1:0], m[`DP_MANT-2:0]};
      end else begin
         enc = {{`HALF_W{1'b0}}, s, be[`SP_EXP_W-1:0], m[`SP_MANT-2:0]};
      end
   endfunction : enc

   function automatic logic [`RES_W-1:0] ovf_res(input logic dp,
                                                 input logic s,
                                                 input rm_t rm);
      logic to_inf;
      to_inf = (rm == RM_NEAR) | ((rm == RM_UP) & ~s) |
               ((rm == RM_DOWN) & s);
      if (to_inf) begin
         ovf_res = enc(dp, s, dp ? `DP_EXP_INF : `SP_EXP_INF, '0);
      end else begin
         ovf_res = enc(dp, s, dp ? `DP_EXP_MAX : `SP_EXP_MAX, '1);
      end
   endfunction : ovf_res

   // ------------------------------------------------------------
   // Control state
   // ------------------------------------------------------------
   logic [`CTRL_W-1:0]  ctrl_q;
   logic [`CTRL_W-1:0]  ctrl_d;
   logic [`ST_W-1:0]    stat_q;
   logic [`ST_W-1:0]    stat_d;
   logic [`ST_W-1:0]    irqm_q;
   logic [`ST_W-1:0]    irqm_d;
   logic [`DATA_W-1:0]  rdata_q;
   logic [`DATA_W-1:0]  rdata_d;
   rm_t                 rm_cur;
   logic                pm;
   logic                um;
   logic                om;

   assign rm_cur = rm_t'(ctrl_q[`CTL_RM +: 2]);
   assign pm     = ctrl_q[`CTL_PM];
   assign um     = ctrl_q[`CTL_UM];
   assign om     = ctrl_q[`CTL_OM];

   // ------------------------------------------------------------
   // Per-lane evaluation
   // ------------------------------------------------------------
   logic [LANES-1:0][`RES_W-1:0] lane_res;
   logic [LANES-1:0]             lane_pe;
   logic [LANES-1:0]             lane_uf;
   logic [LANES-1:0]             lane_ov;

   for (genvar g = 0; g < LANES; g++) begin : g_lane
      fpx_rnd_if rn_if ();
      fpx_rnd_if rd_if ();
      fpx_round u_rn (.r(rn_if.rnd));
      fpx_round u_rd (.r(rd_if.rnd));

      logic signed [`EXP_W-1:0] e;
      logic signed [`EXP_W-1:0] er;
      logic signed [`EXP_W-1:0] emin;
      logic signed [`EXP_W-1:0] emax;
      logic signed [`EXP_W-1:0] bias;
      logic signed [`EXP_W-1:0] scale;
      logic signed [`EXP_W-1:0] dn;
      logic                     ap;
      logic                     fi;
      logic                     tiny;
      logic                     huge;
      logic                     dn_norm;
      rm_t                      rm_eff;
      logic [`RES_W-1:0]        res;
      logic                     pe;
      logic                     uf;
      logic                     ov;

      assign e      = $signed(exp_in[g]);
      assign emin   = dp_in ? `DP_EMIN : `SP_EMIN;
      assign emax   = dp_in ? `DP_EMAX : `SP_EMAX;
      assign bias   = dp_in ? `DP_BIAS : `SP_BIAS;
      assign scale  = dp_in ? `DP_SCALE : `SP_SCALE;
      assign dn     = emin - e;
      assign fi     = (op_class_in == OP_CVT_FI) |
                      (op_class_in == OP_CVT_FIT);
      // Truncating conversions always chop
      assign rm_eff = (op_class_in == OP_CVT_FIT) ? RM_ZERO : rm_cur; // [RULE8]

      assign rn_if.sig   = sig_in[g];
      assign rn_if.shift = '0;
      assign rn_if.dp    = dp_in;
      assign rn_if.rm    = rm_eff;
      assign rn_if.sign  = sign_in[g];
      // Second rounder denormalises; deep shifts collapse to sticky
      assign rd_if.sig   = sig_in[g];
      assign rd_if.shift = (dn > `SHIFT_LIM) ? `SHIFT_MAX :
                           (dn > 0) ? dn[`SH_W-1:0] : '0;
      assign rd_if.dp    = dp_in;
      assign rd_if.rm    = rm_eff;
      assign rd_if.sign  = sign_in[g];

      always_comb begin
         ap   = (op_class_in == OP_ARITH) |
                (op_class_in == OP_NARROW); // [RULE3]
         er   = rn_if.carry ? e + `EXP_ONE : e;
         // Tininess is judged after rounding, exponent unbounded
         tiny = ~zero_in[g] & (er < emin); // [RULE1] [RULE2]
         huge = ~fi & ~zero_in[g] & (er > emax);
         dn_norm = dp_in ? rd_if.mant[`DP_MANT-1] : rd_if.mant[`SP_MANT-1];
         res  = enc(dp_in, sign_in[g], `BE_W'(er + bias), rn_if.mant);
         pe   = rn_if.inexact; // [RULE7] [RULE9] [RULE14]
         uf   = 1'b0;
         ov   = 1'b0;
         if (zero_in[g]) begin
            res = enc(dp_in, sign_in[g], `EXP_DN, '0);
            pe  = 1'b0;
         end else if (fi) begin
            res = `RES_W'(rn_if.mant);
            pe  = rn_if.inexact; // [RULE8]
         end else if (huge) begin
            ov = 1'b1;
            if (om) begin
               res = ovf_res(dp_in, sign_in[g], rm_eff); // [RULE15] [RULE12]
               pe  = 1'b1; // [RULE10]
            end else begin
               res = enc(dp_in, sign_in[g], `BE_W'(er - scale + bias),
                         rn_if.mant);
            end
         end else if (tiny) begin
            if (um | ~ap) begin
               // Rounding may carry a denormal up to the least normal
               res = enc(dp_in, sign_in[g],
                         dn_norm ? `EXP_MINN : `EXP_DN, rd_if.mant); // [RULE4]
               uf  = ap & rd_if.inexact; // [RULE3] [RULE4] [RULE13]
               pe  = rd_if.inexact; // [RULE10]
            end else begin
               res = enc(dp_in, sign_in[g], `BE_W'(er + scale + bias),
                         rn_if.mant); // [RULE5] [RULE6]
               uf  = 1'b1; // [RULE5] [RULE6]
            end
         end
      end

      assign lane_res[g] = res;
      assign lane_pe[g]  = pe & lane_en_in[g];
      assign lane_uf[g]  = uf & lane_en_in[g];
      assign lane_ov[g]  = ov & lane_en_in[g];
   end

   // ------------------------------------------------------------
   // Result stage
   // ------------------------------------------------------------
   logic                          vld_q;
   logic                          vld_d;
   logic [LANES-1:0][`RES_W-1:0]  res_q;
   logic [LANES-1:0][`RES_W-1:0]  res_d;
   logic [`FL_W-1:0]              flags_q;
   logic [`FL_W-1:0]              flags_d;
   logic [`FL_W-1:0]              cause_q;
   logic [`FL_W-1:0]              cause_d;
   logic                          any_uo;

   always_comb begin
      vld_d   = op_valid_in;
      res_d   = res_q;
      flags_d = '0;
      cause_d = '0;
      any_uo  = 1'b0;
      if (op_valid_in) begin
         for (int i = 0; i < LANES; i++) begin
            if (lane_en_in[i]) begin
               res_d[i] = lane_res[i];
            end
         end
         flags_d[`FL_PE] = |lane_pe; // [RULE16]
         flags_d[`FL_UE] = |lane_uf; // [RULE16]
         flags_d[`FL_OE] = |lane_ov; // [RULE16]
         cause_d[`FL_UE] = flags_d[`FL_UE] & ~um;
         cause_d[`FL_OE] = flags_d[`FL_OE] & ~om;
         any_uo = cause_d[`FL_UE] | cause_d[`FL_OE];
         // An unmasked U/O trap takes precedence over inexact
         cause_d[`FL_PE] = flags_d[`FL_PE] & ~pm & ~any_uo; // [RULE11]
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         vld_q   <= 1'b0;
         res_q   <= '0;
         flags_q <= '0;
         cause_q <= '0;
      end else begin
         vld_q   <= vld_d;
         res_q   <= res_d;
         flags_q <= flags_d;
         cause_q <= cause_d;
      end
   end

   assign res_valid_out = vld_q;
   assign res_out       = res_q;
   assign flags_out     = flags_q;
   assign cause_out     = cause_q;
   assign trap_out      = |cause_q;

   // ------------------------------------------------------------
   // Register port and sticky status
   // ------------------------------------------------------------
   always_comb begin
      ctrl_d  = ctrl_q;
      irqm_d  = irqm_q;
      stat_d  = stat_q;
      rdata_d = '0;
      if (reg_wr_in) begin
         case (reg_addr_in)
            `CTRL_OFS: ctrl_d = reg_wdata_in[`CTRL_W-1:0];
            `IRQM_OFS: irqm_d = reg_wdata_in[`ST_W-1:0];
            default:   ctrl_d = ctrl_q;
         endcase
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            `CTRL_OFS: rdata_d = `DATA_W'(ctrl_q);
            `IRQM_OFS: rdata_d = `DATA_W'(irqm_q);
            `STAT_OFS: begin
               rdata_d = `DATA_W'(stat_q);
               stat_d  = '0;
            end
            default:   rdata_d = '0;
         endcase
      end
      // New events win over a clearing read in the same cycle
      if (vld_q) begin
         stat_d = stat_d | {trap_out, flags_q}; // [RULE16]
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl_q  <= `CTRL_RST;
         irqm_q  <= '0;
         stat_q  <= '0;
         rdata_q <= '0;
      end else begin
         ctrl_q  <= ctrl_d;
         irqm_q  <= irqm_d;
         stat_q  <= stat_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign irq_out       = |(stat_q & irqm_q);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   a_uf_scope_only: assert property ( // [RULE3]
      op_valid_in && (op_class_in == OP_SQRT || op_class_in == OP_CVT_IF ||
                      op_class_in == OP_CVT_FI || op_class_in == OP_CVT_FIT)
      |=> !flags_out[`FL_UE])
      else $error("underflow flagged outside its operations");

   a_masked_uf_pe: assert property ( // [RULE4]
      res_valid_out && flags_out[`FL_UE] && $past(um) |-> flags_out[`FL_PE])
      else $error("masked underflow without inexact");

   a_unm_uf_sp: assert property ( // [RULE5]
      op_valid_in && !dp_in && !um && lane_uf[0]
      |=> trap_out && cause_out[`FL_UE] && !cause_out[`FL_PE])
      else $error("single unmasked underflow not trapped");

   a_unm_uf_dp: assert property ( // [RULE6]
      op_valid_in && dp_in && !um && lane_uf[0] && !lane_ov[0]
      |=> cause_out[`FL_UE] ##1 stat_q[`ST_TRAP])
      else $error("double unmasked underflow not trapped");

   a_pe_gated: assert property ( // [RULE11]
      res_valid_out && cause_out[`FL_PE]
      |-> !(flags_out[`FL_UE] && !$past(um)) &&
          !(flags_out[`FL_OE] && !$past(om)))
      else $error("inexact trap beside unmasked U/O");

   a_pe_alone: assert property ( // [RULE14]
      res_valid_out && flags_out == `FL_W'(1) && !$past(pm) |-> trap_out)
      else $error("unmasked inexact not raised");

   a_masked_ov: assert property ( // [RULE15]
      res_valid_out && flags_out[`FL_OE] && $past(om)
      |-> flags_out[`FL_PE] && !cause_out[`FL_OE])
      else $error("masked overflow flags wrong");

   a_sticky_set: assert property ( // [RULE16]
      res_valid_out && flags_out[`FL_UE] |=> stat_q[`FL_UE] ##1
      (stat_q[`FL_UE] || $past(reg_rd_in && reg_addr_in == `STAT_OFS)))
      else $error("sticky underflow lost");

   a_rd_latency: assert property (
      reg_rd_in && reg_addr_in == `CTRL_OFS && !reg_wr_in
      |=> reg_rdata_out == `DATA_W'($past(ctrl_q)))
      else $error("control read data wrong");

   c_masked_uf: cover property (res_valid_out && flags_out[`FL_UE] &&
                                !trap_out);
   c_unm_uf:    cover property (res_valid_out && cause_out[`FL_UE]);
   c_unm_pe:    cover property (res_valid_out && cause_out[`FL_PE]);
   c_irq:       cover property ($rose(irq_out));

endmodule : fpx_unit

// ==== verif/tb_simd_fp_underflow_inexact_flags.sv ====
// Self-checking bench for the underflow/inexact result unit.
// Assumes fpx_unit with its rounder and the cfg header on the path.
`include "fpx_cfg.svh"
module tb_simd_fp_underflow_inexact_flags;
   timeunit 1ns;
   timeprecision 1ns;
   import fpx_pkg::*;
   localparam int LANES = 4;
   localparam logic [63:0] TOP = 64'h8000_0000_0000_0000;
   localparam logic [63:0] TOPX = 64'h8000_0000_0000_0001;
   // ----------
   // Stimulus and observed signals
   // ----------
   logic                           core_clk_in  = 1'b0;
   logic                           nrst_in      = 1'b0;
   logic                           op_valid_in  = 1'b0;
   op_class_t                      op_class_in  = OP_ARITH;
   logic                           dp_in        = 1'b0;
   logic [LANES-1:0]               lane_en_in   = '0;
   logic [LANES-1:0]               sign_in      = '0;
   logic [LANES-1:0]               zero_in      = '0;
   logic [LANES-1:0][`EXP_W-1:0]   exp_in       = '0;
   logic [LANES-1:0][`SIG_W-1:0]   sig_in       = '0;
   logic [`ADDR_W-1:0]             reg_addr_in  = '0;
   logic [`DATA_W-1:0]             reg_wdata_in = '0;
   logic                           reg_wr_in    = 1'b0;
   logic                           reg_rd_in    = 1'b0;
   logic                           res_valid_out;
   logic [LANES-1:0][`RES_W-1:0]   res_out;
   logic [`FL_W-1:0]               flags_out;
   logic [`FL_W-1:0]               cause_out;
   logic                           trap_out;
   logic [`DATA_W-1:0]             reg_rdata_out;
   logic                           irq_out;
   int                             mismatches   = 0;
   int                             n_checks     = 0;
   op_class_t                      pl[4] = '{OP_ARITH, OP_SQRT,
                                             OP_CVT_FF, OP_CVT_IF};
   fpx_unit #(.LANES(LANES)) dut (.core_clk_in(core_clk_in),
      .nrst_in(nrst_in), .op_valid_in(op_valid_in),
      .op_class_in(op_class_in), .dp_in(dp_in), .lane_en_in(lane_en_in),
      .sign_in(sign_in), .zero_in(zero_in), .exp_in(exp_in),
      .sig_in(sig_in), .res_valid_out(res_valid_out), .res_out(res_out),
      .flags_out(flags_out), .cause_out(cause_out), .trap_out(trap_out),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
   always #50 core_clk_in = ~core_clk_in;
   // ----------
   // Compare and access tasks
   // ----------
   task automatic tally(input logic bad, input string what);
      n_checks++;
      if (bad) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : tally
   task automatic chk_res(input logic [`RES_W-1:0] g, e);
      tally(g !== e, $sformatf("result %h want %h", g, e));
   endtask : chk_res
   task automatic chk_fl(input logic [`FL_W-1:0] g, e);
      tally(g !== e, $sformatf("flags %b want %b", g, e));
   endtask : chk_fl
   task automatic chk_reg(input logic [`DATA_W-1:0] g, e);
      tally(g !== e, $sformatf("read %h want %h", g, e));
   endtask : chk_reg
   task automatic chk_bit(input logic g, e);
      tally(g !== e, $sformatf("bit %b want %b", g, e));
   endtask : chk_bit
   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] v);
      @(posedge core_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= v;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [`ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge core_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk_reg(reg_rdata_out, e);
   endtask : rd
   task automatic lane(input int i, input logic s,
                       input logic [13:0] e, input logic [63:0] g);
      sign_in[i] <= s;
      exp_in[i] <= e;
      sig_in[i] <= g;
   endtask : lane
   // Same operand in every lane, all lanes enabled
   task automatic op1(input op_class_t c, input logic d, input logic s,
                      input logic [13:0] e, input logic [63:0] g);
      @(posedge core_clk_in);
      for (int i = 0; i < LANES; i++) begin
         lane(i, s, e, g);
      end
      go(c, d, 4'hf);
   endtask : op1
   task automatic go(input op_class_t c, input logic d,
                     input logic [LANES-1:0] en);
      @(posedge core_clk_in);
      op_valid_in <= 1'b1;
      op_class_in <= c;
      dp_in <= d;
      lane_en_in <= en;
      @(posedge core_clk_in);
      op_valid_in <= 1'b0;
      #1;
      chk_bit(res_valid_out, 1'b1);
   endtask : go
   task automatic want(input logic [63:0] r, input logic [2:0] f, c);
      chk_res(res_out[0], r);
      chk_fl(flags_out, f);
      chk_fl(cause_out, c);
      chk_bit(trap_out, |c);
   endtask : want
   task automatic done(input string t);
      $display("test %s done", t);
   endtask : done
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   // ----------
   // Watchdog: the sequence needs under two hundred cycles
   // ----------
   initial begin
      #(3000 * 100);
      mismatches++;
      results();
   end
   // ----------
   // Main sequence
   // ----------
   initial begin
      logic s;
      logic [1:0] m;
      logic big;
      repeat (16) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      rd(4'h0, 32'h1c);
      rd(4'h1, 32'h0);
      rd(4'h2, 32'h0);
      rd(4'hf, 32'h0);
      wr(4'h1, 32'hf);
      rd(4'h1, 32'h0);
      done("registers");
      foreach (pl[i]) begin
         op1(pl[i], 1'b0, 1'b0, 14'h0000, TOPX);
         want(64'h3f80_0000, 3'b001, 3'b000);
      end
      rd(4'h1, 32'h1);
      rd(4'h1, 32'h0);
      done("inexact");
      op1(OP_ARITH, 1'b0, 1'b0, 14'h3f81, TOP);
      want(64'h0040_0000, 3'b000, 3'b000);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h3f81, TOPX);
      want(64'h0040_0000, 3'b011, 3'b000);
      op1(OP_NARROW, 1'b0, 1'b0, 14'h3f81, TOPX);
      want(64'h0040_0000, 3'b011, 3'b000);
      op1(OP_ARITH, 1'b1, 1'b0, 14'h3c01, TOP);
      want(64'h0008_0000_0000_0000, 3'b000, 3'b000);
      op1(OP_ARITH, 1'b1, 1'b0, 14'h3c01, TOPX);
      want(64'h0008_0000_0000_0000, 3'b011, 3'b000);
      done("masked underflow");
      wr(4'h0, 32'h14);
      op1(OP_SQRT, 1'b0, 1'b0, 14'h3f81, TOP);
      want(64'h0040_0000, 3'b000, 3'b000);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h3f81, TOP);
      want(64'h6000_0000, 3'b010, 3'b010);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h3f7e, TOP);
      want(64'h5e80_0000, 3'b010, 3'b010);
      op1(OP_ARITH, 1'b1, 1'b0, 14'h3bfa, TOP);
      want(64'h5f90_0000_0000_0000, 3'b010, 3'b010);
      done("unmasked underflow");
      wr(4'h0, 32'h18);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h0080, TOP);
      want(64'h7f80_0000, 3'b101, 3'b001);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h3f81, TOPX);
      want(64'h0040_0000, 3'b011, 3'b001);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h0000, TOPX);
      want(64'h3f80_0000, 3'b001, 3'b001);
      wr(4'h0, 32'h10);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h3f7e, TOPX);
      want(64'h5e80_0000, 3'b011, 3'b010);
      wr(4'h0, 32'h8);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h0080, TOPX);
      want(64'h1f80_0000, 3'b101, 3'b100);
      done("unmasked inexact");
      // Sign and rounding direction pick infinity or largest finite
      for (int i = 0; i < 8; i++) begin
         s = i[2];
         m = i[1:0];
         big = (m == 2'h0) || (m == 2'h2 && !s) || (m == 2'h1 && s);
         wr(4'h0, {27'h0, 3'b111, m});
         op1(OP_ARITH, 1'b0, s, 14'h0080, TOP);
         want({32'h0, s, big ? 31'h7f80_0000 : 31'h7f7f_ffff},
              3'b101, 3'b000);
      end
      done("masked overflow");
      wr(4'h0, 32'h1c);
      op1(OP_CVT_FIT, 1'b0, 1'b0, 14'h0000, 64'h0000_05c0_0000_0000);
      want(64'h5, 3'b001, 3'b000);
      op1(OP_CVT_FI, 1'b0, 1'b0, 14'h0000, 64'h0000_05c0_0000_0000);
      want(64'h6, 3'b001, 3'b000);
      done("conversions");
      @(posedge core_clk_in);
      lane(0, 1'b0, 14'h0000, TOPX);
      lane(1, 1'b0, 14'h3f81, TOP);
      lane(2, 1'b0, 14'h0080, TOP);
      lane(3, 1'b0, 14'h3f81, TOPX);
      go(OP_ARITH, 1'b0, 4'h7);
      want(64'h3f80_0000, 3'b101, 3'b000);
      chk_res(res_out[1], 64'h0040_0000);
      chk_res(res_out[2], 64'h7f80_0000);
      chk_res(res_out[3], 64'h6);
      rd(4'h1, 32'hf);
      done("packed");
      wr(4'h2, 32'h2);
      rd(4'h2, 32'h2);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h3f81, TOPX);
      @(posedge core_clk_in);
      #1;
      chk_bit(irq_out, 1'b1);
      rd(4'h1, 32'h3);
      @(posedge core_clk_in);
      #1;
      chk_bit(irq_out, 1'b0);
      op1(OP_ARITH, 1'b0, 1'b0, 14'h0000, TOPX);
      @(posedge core_clk_in);
      #1;
      chk_bit(irq_out, 1'b0);
      rd(4'h1, 32'h1);
      done("interrupt");
      results();
   end
endmodule : tb_simd_fp_underflow_inexact_flags
